// *** design/stt_pkg.sv ***
package stt_pkg;
    typedef logic [31:0] stt_word_t;
    typedef logic [23:0] stt_count_t;
    typedef logic [1:0]  stt_resp_t;
    localparam stt_resp_t STT_OKAY   = 2'h0;
    localparam stt_resp_t STT_SLVERR = 2'h2;
endpackage

// *** design/stt_ref_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module stt_ref_sync
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic refIn,
    output logic      refEdge
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;

    // Rising change counts once stages two and three agree
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            lvl_q   <= 1'b0;
            refEdge <= 1'b0;
        end
        else
        begin
            s1_q    <= refIn;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            refEdge <= 1'b0;
            if (s2_q == s3_q && s3_q != lvl_q)
            begin
                lvl_q   <= s3_q;
                refEdge <= s3_q;
            end
        end
    end
endmodule
`default_nettype wire

// *** design/stt_regs.svh ***
// What this block does
// - 24-bit down counter; at zero reloads on next count edge, then keeps counting
// - Counter holds its value while the core is halted for debug
// - Bit 16 flag shows zero reached since last read; reading clears it
// - Bit 2 picks count clock: 0 reference, 1 processor clock
// - Bit 1 gates the tick exception request on reaching zero
// - Bit 0 enables counting; enable first loads reload value, then counts
// - Each zero reached while enabled sets flag, maybe requests, then reloads
// - Control/status at 0xE000E010, resets to 0x00000004, reserved bits zero, privileged
// - Reload and current registers read/write, reset to zero, privileged only
// - Calibration at 0xE000E01C is read-only, reads {!HAS_REF, SKEW, 6'h00, TENMS}, privileged only
// - Reload value sits in bits 23:0; upper bits reserved
// - Any write to current value clears counter and the flag
// - Flag and request fire on step from 1 to 0 only
// - Without reference clock, select bit reads one and calibration top bit set
`ifndef STT_REGS_SVH
`define STT_REGS_SVH

`define STT_ADDR_CTRL   32'hE000E010
`define STT_ADDR_RELOAD 32'hE000E014
`define STT_ADDR_CURR   32'hE000E018
`define STT_ADDR_CALIB  32'hE000E01C
`define STT_CTRL_RESET  32'h00000004
`define STT_CALIB_RESET 32'hC0000000
`define STT_BIT_ENABLE  0
`define STT_BIT_IRQEN   1
`define STT_BIT_CLKSEL  2
`define STT_BIT_FLAG    16
`define STT_BIT_NO_REFERENCE_CLOCK   31
`define STT_CNT_W       24

`endif

// *** design/stt_timer.sv ***
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "stt_regs.svh"
module stt_timer
#(
    parameter bit         HAS_REF = 1'b0,
    parameter logic [23:0] TENMS  = 24'h000000,
    parameter bit         SKEW    = 1'b1
)
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              refClk,
    input  wire logic              debugHalt,
    output logic                   tickRequest,
    input  wire stt_pkg::stt_word_t s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire stt_pkg::stt_word_t s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output stt_pkg::stt_resp_t     s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire stt_pkg::stt_word_t s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output stt_pkg::stt_word_t     s_axi_rdata,
    output stt_pkg::stt_resp_t     s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    import stt_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic       enable_q;
    logic       irqEn_q;
    logic       clkSel_q;
    logic       flag_q;
    stt_count_t reload_q;
    stt_count_t count_q;
    logic       awHeld_q;
    logic       wHeld_q;
    stt_word_t  awAddr_q;
    logic       awPriv_q;
    stt_word_t  wData_q;
    logic       refEdge;
    logic       wrFire;
    logic       rdFire;
    logic       wrOk;
    logic       rdOk;
    logic       stepEn;
    logic       hitZero;
    logic       loadStart;
    stt_word_t  rdValue;
    stt_word_t  calibValue;

    stt_ref_sync u_sync
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .refIn   (refClk),
        .refEdge (refEdge)
    );

    // ------------------------------------------------------------
    // Bus write side
    // ------------------------------------------------------------
    // Address and data may come in either order; both are held
    assign wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign wrOk = awPriv_q &&
        (awAddr_q == `STT_ADDR_CTRL || awAddr_q == `STT_ADDR_RELOAD ||
         awAddr_q == `STT_ADDR_CURR);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= 32'h00000000;
            awPriv_q      <= 1'b0;
            wData_q       <= 32'h00000000;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= STT_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_q      <= 1'b1;
                awAddr_q      <= s_axi_awaddr;
                awPriv_q      <= s_axi_awprot[0];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_q      <= 1'b1;
                wData_q      <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (wrFire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrOk ? STT_OKAY : STT_SLVERR;
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus read side
    // ------------------------------------------------------------
    assign rdFire = s_axi_arvalid && s_axi_arready;
    assign rdOk   = s_axi_arprot[0];

    assign calibValue = {!HAS_REF, SKEW, 6'h00, TENMS};

    always_comb
    begin
        rdValue = 32'h00000000;
        if (s_axi_araddr == `STT_ADDR_CTRL)
        begin
            rdValue = {15'h0000, flag_q, 13'h0000, clkSel_q, irqEn_q, enable_q};
        end
        else if (s_axi_araddr == `STT_ADDR_RELOAD)
        begin
            rdValue = {8'h00, reload_q};
        end
        else if (s_axi_araddr == `STT_ADDR_CURR)
        begin
            rdValue = {8'h00, count_q};
        end
        else if (s_axi_araddr == `STT_ADDR_CALIB)
        begin
            rdValue = calibValue;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= STT_OKAY;
        end
        else
        begin
            if (rdFire)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rdOk ? rdValue : 32'h00000000;
                s_axi_rresp   <= (rdOk && (s_axi_araddr == `STT_ADDR_CTRL ||
                    s_axi_araddr == `STT_ADDR_RELOAD || s_axi_araddr == `STT_ADDR_CURR ||
                    s_axi_araddr == `STT_ADDR_CALIB)) ? STT_OKAY : STT_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Control and reload registers
    // ------------------------------------------------------------
    logic ctrlWr;
    logic currWr;
    logic ctrlRd;
    assign ctrlWr = wrFire && wrOk && awAddr_q == `STT_ADDR_CTRL;
    assign currWr = wrFire && wrOk && awAddr_q == `STT_ADDR_CURR;
    assign ctrlRd = rdFire && rdOk && s_axi_araddr == `STT_ADDR_CTRL;
    // Enable rising through a write loads reload first
    assign loadStart = ctrlWr && wData_q[`STT_BIT_ENABLE] && !enable_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            enable_q <= 1'b0;
            irqEn_q  <= 1'b0;
            clkSel_q <= 1'b1;
            reload_q <= 24'h000000;
        end
        else
        begin
            if (ctrlWr)
            begin
                enable_q <= wData_q[`STT_BIT_ENABLE];
                irqEn_q  <= wData_q[`STT_BIT_IRQEN];
                clkSel_q <= HAS_REF ? wData_q[`STT_BIT_CLKSEL] : 1'b1;
            end
            if (wrFire && wrOk && awAddr_q == `STT_ADDR_RELOAD)
            begin
                reload_q <= wData_q[23:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Reference edges are lost during debug halt by design
    assign stepEn  = enable_q && !debugHalt && (clkSel_q || refEdge);
    assign hitZero = stepEn && count_q == 24'h000001;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            count_q <= 24'h000000;
        end
        else if (currWr)
        begin
            count_q <= 24'h000000;
        end
        else if (loadStart)
        begin
            count_q <= reload_q;
        end
        else if (stepEn)
        begin
            count_q <= (count_q == 24'h000000) ? reload_q : count_q - 24'h000001;
        end
    end

    // Set wins over read-clear; current-value write clears outright
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            flag_q      <= 1'b0;
            tickRequest <= 1'b0;
        end
        else
        begin
            if (hitZero && !currWr)
            begin
                flag_q <= 1'b1;
            end
            else if (ctrlRd || currWr)
            begin
                flag_q <= 1'b0;
            end
            tickRequest <= hitZero && irqEn_q && !currWr;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_flag_set;
        @(posedge clk_sys) disable iff (rst)
        (hitZero && !currWr) |=> flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set at zero");

    property p_wrap;
        @(posedge clk_sys) disable iff (rst)
        (stepEn && count_q == 24'h000000 && !currWr && !loadStart) |=> count_q == $past(reload_q);
    endproperty
    a_wrap: assert property (p_wrap) else $error("no reload after zero");

    property p_halt;
        @(posedge clk_sys) disable iff (rst)
        (debugHalt && !currWr && !loadStart) |=> $stable(count_q);
    endproperty
    a_halt: assert property (p_halt) else $error("counted while halted");

    property p_read_clear;
        @(posedge clk_sys) disable iff (rst)
        (ctrlRd && !hitZero) |=> !flag_q;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag not cleared by read");

    property p_irq;
        @(posedge clk_sys) disable iff (rst)
        tickRequest |-> $past(irqEn_q) && $past(count_q) == 24'h000001;
    endproperty
    a_irq: assert property (p_irq) else $error("request without cause");

    property p_curr_clear;
        @(posedge clk_sys) disable iff (rst)
        currWr |=> count_q == 24'h000000 && !flag_q;
    endproperty
    a_curr_clear: assert property (p_curr_clear) else $error("current write not clearing");

    property p_start;
        @(posedge clk_sys) disable iff (rst)
        (loadStart && !currWr) |=> count_q == $past(reload_q) && enable_q;
    endproperty
    a_start: assert property (p_start) else $error("enable did not load reload");

    property p_no_reference_clock;
        @(posedge clk_sys) disable iff (rst)
        !HAS_REF |-> clkSel_q && calibValue[31];
    endproperty
    a_no_reference_clock: assert property (p_no_reference_clock) else $error("select bit not stuck at one");

    property p_ref_step;
        @(posedge clk_sys) disable iff (rst)
        (enable_q && !clkSel_q && !refEdge && !currWr && !loadStart) |=> $stable(count_q);
    endproperty
    a_ref_step: assert property (p_ref_step) else $error("step without reference edge");

    property p_one_to_zero;
        @(posedge clk_sys) disable iff (rst)
        $rose(flag_q) |-> $past(count_q) == 24'h000001 && $past(stepEn);
    endproperty
    a_one_to_zero: assert property (p_one_to_zero) else $error("flag set off a 1 to 0 step");

    property p_tick_pulse;
        @(posedge clk_sys) disable iff (rst)
        tickRequest |=> !tickRequest;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("request wider than one cycle");

    property p_enable_off;
        @(posedge clk_sys) disable iff (rst)
        (!enable_q && !currWr && !loadStart) |=> $stable(count_q);
    endproperty
    a_enable_off: assert property (p_enable_off) else $error("counted while disabled");
endmodule
`default_nettype wire

// *** testbench/stt_exc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Exception logic: logs when each tick request lands
// ------------------------------------------------
module stt_exc_model
(
    input  wire logic   clk_sys,
    input  wire logic   rst,
    input  wire logic   tickRequest,
    output logic [31:0] nTicks,
    output logic [31:0] tLast,
    output logic [31:0] tPrev
);
    logic [31:0] cycle_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cycle_q <= 32'h0;
            nTicks  <= 32'h0;
            tLast   <= 32'h0;
            tPrev   <= 32'h0;
        end
        else
        begin
            cycle_q <= cycle_q + 32'h1;
            // Pulse is one cycle wide, so every high sample is a new request
            if (tickRequest)
            begin
                nTicks <= nTicks + 32'h1;
                tPrev  <= tLast;
                tLast  <= cycle_q;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/system_tick_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin nMismatch++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module system_tick_timer_tb;
    import stt_pkg::*;
    localparam stt_word_t CTRL  = 32'hE000E010;
    localparam stt_word_t RLD   = 32'hE000E014;
    localparam stt_word_t CURR  = 32'hE000E018;
    localparam stt_word_t CALIB = 32'hE000E01C;
    localparam int        K     = 5;
    logic        clk_sys = 1'h0, rst = 1'h1, refClk = 1'h0, debugHalt = 1'h0, tickRequest;
    stt_word_t   s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    stt_resp_t   s_axi_bresp, s_axi_rresp, r;
    logic [31:0] nTicks, tLast, tPrev, n0;
    stt_word_t   mReload, d1, d2, rdNoref, cNoref;
    int          seed, checked = 0, nMismatch = 0;

    always #50 clk_sys = ~clk_sys;

    stt_timer #(.HAS_REF(1'h1), .TENMS(24'h0), .SKEW(1'h1)) dut_u (.clk_sys, .rst, .refClk,
        .debugHalt, .tickRequest, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    stt_exc_model exc_u (.clk_sys, .rst, .tickRequest, .nTicks, .tLast, .tPrev);
    // Twin without reference clock shares the bus; only its read data is watched
    stt_timer #(.HAS_REF(1'h0), .TENMS(24'h0), .SKEW(1'h1)) no_reference_clock_u (.clk_sys, .rst, .refClk,
        .debugHalt, .tickRequest(), .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(),
        .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(rdNoref), .s_axi_rresp(),
        .s_axi_rvalid(), .s_axi_rready);

    // ------------------------------------------------
    // Bus tasks: ready sampled at negedge equals value seen by next posedge
    // ------------------------------------------------
    task automatic axWr(input stt_word_t a, input stt_word_t d, input logic [2:0] p,
                        input stt_resp_t er);
        logic aT, wT, bT;
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awprot  <= p;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        bT = 1'h0;
        while (!bT)
        begin
            @(negedge clk_sys);
            aT = s_axi_awvalid & s_axi_awready;
            wT = s_axi_wvalid & s_axi_wready;
            bT = s_axi_bvalid;
            r  = s_axi_bresp;
            @(posedge clk_sys);
            if (aT) s_axi_awvalid <= 1'h0;
            if (wT) s_axi_wvalid <= 1'h0;
            if (bT) s_axi_bready <= 1'h0;
        end
        `CHK(r, er)
    endtask

    task automatic axRd(input stt_word_t a, input logic [2:0] p, output stt_word_t d);
        logic aT, rT;
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arprot  <= p;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        rT = 1'h0;
        while (!rT)
        begin
            @(negedge clk_sys);
            aT = s_axi_arvalid & s_axi_arready;
            rT = s_axi_rvalid;
            d  = s_axi_rdata;
            cNoref = rdNoref;
            r  = s_axi_rresp;
            @(posedge clk_sys);
            if (aT) s_axi_arvalid <= 1'h0;
            if (rT) s_axi_rready <= 1'h0;
        end
    endtask

    task automatic rdChk(input stt_word_t a, input stt_word_t e);
        stt_word_t d;
        axRd(a, 3'h1, d);
        `CHK(r, STT_OKAY)
        `CHK(d, e)
    endtask

    task automatic give_verdict;
        $display("checked=%0d mismatches=%0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #(30000 * 100);
        nMismatch++;
        give_verdict();
    end

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial
    begin
        seed = 63207;
        repeat (10) @(posedge clk_sys);
        rst <= 1'h0;
        rdChk(CTRL, 32'h00000004);
        rdChk(CALIB, 32'h40000000);
        `CHK(cNoref, 32'hC0000000)
        axWr(CALIB, 32'hFFFFFFFF, 3'h1, STT_SLVERR);
        rdChk(CALIB, 32'h40000000);
        axWr(CTRL, 32'h00000007, 3'h0, STT_SLVERR);
        rdChk(CTRL, 32'h00000004);
        axRd(32'hE000E020, 3'h1, d1);
        `CHK(r, STT_SLVERR)
        axWr(RLD, 32'hFFFFFFFF, 3'h1, STT_OKAY);
        rdChk(RLD, 32'h00FFFFFF);
        mReload = stt_word_t'(5 + ($random(seed) & 15));
        axWr(RLD, mReload, 3'h1, STT_OKAY);
        axWr(CURR, $random(seed), 3'h1, STT_OKAY);
        rdChk(CURR, 32'h0);
        axWr(CTRL, 32'h00000007, 3'h1, STT_OKAY);
        n0 = nTicks;
        for (int i = 0; i < 400 && nTicks < n0 + 3; i++) @(posedge clk_sys);
        `CHK(tLast - tPrev, mReload + 32'h1)
        axWr(CTRL, 32'h00000004, 3'h1, STT_OKAY);
        rdChk(CTRL, 32'h00010004);
        rdChk(CTRL, 32'h00000004);
        axWr(CTRL, 32'h00000005, 3'h1, STT_OKAY);
        n0 = nTicks;
        repeat (3 * (mReload + 1)) @(posedge clk_sys);
        `CHK(nTicks, n0)
        rdChk(CTRL, 32'h00010005);
        axWr(CURR, $random(seed), 3'h1, STT_OKAY);
        rdChk(CTRL, 32'h00000005);
        debugHalt <= 1'h1;
        axRd(CURR, 3'h1, d1);
        repeat (20) @(posedge clk_sys);
        axRd(CURR, 3'h1, d2);
        `CHK(d2, d1)
        debugHalt <= 1'h0;
        axWr(CTRL, 32'h00000004, 3'h1, STT_OKAY);
        axWr(RLD, 32'h0, 3'h1, STT_OKAY);
        axWr(CURR, 32'h0, 3'h1, STT_OKAY);
        rdChk(CTRL, 32'h00000004);
        axWr(CTRL, 32'h00000005, 3'h1, STT_OKAY);
        repeat (30) @(posedge clk_sys);
        rdChk(CTRL, 32'h00000005);
        rdChk(CURR, 32'h0);
        axWr(CTRL, 32'h00000004, 3'h1, STT_OKAY);
        axWr(RLD, 32'd1000, 3'h1, STT_OKAY);
        axWr(CTRL, 32'h00000001, 3'h1, STT_OKAY);
        rdChk(CTRL, 32'h00000001);
        `CHK(cNoref, 32'h00000005)
        rdChk(CURR, 32'd1000);
        repeat (K)
        begin
            repeat (3) @(posedge clk_sys);
            refClk <= 1'h1;
            repeat (3) @(posedge clk_sys);
            refClk <= 1'h0;
        end
        repeat (6) @(posedge clk_sys);
        rdChk(CURR, 32'd1000 - K);
        give_verdict();
    end
endmodule
`default_nettype wire
